// ===== core/nba_regs.svh
// Register offsets, field positions, reset values and constants of the ALU
`ifndef NBA_REGS_SVH
`define NBA_REGS_SVH

// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define NBA_PSW_OFS 8'h00
`define NBA_STAT_OFS 8'h04

// ***********************************************************************
// Program status word fields
// ***********************************************************************
`define NBA_PSW_CARRY 0
`define NBA_PSW_ZERO 1
`define NBA_PSW_CMPONLY 2
`define NBA_PSW_BCD 3
`define NBA_PSW_RST 4'h0

// ***********************************************************************
// Status register fields
// ***********************************************************************
`define NBA_STAT_TMPA_LSB 0
`define NBA_STAT_TMPB_LSB 4
`define NBA_STAT_RES_LSB 8
`define NBA_STAT_BUSY 12
`define NBA_STAT_SKIP 13

// ***********************************************************************
// Bus answers and decimal limits
// ***********************************************************************
`define NBA_RESP_OKAY 2'h0
`define NBA_RESP_SLVERR 2'h2
`define NBA_BCD_TEN 5'h0A
`define NBA_BCD_TWENTY 5'h14
`define NBA_BCD_NEG_TEN 5'h16

`endif

// ===== core/nba_pkg.sv
// Types shared by the nibble ALU and its decimal converter
package nba_pkg;

  // *********************************************************************
  // Instruction classes seen by the ALU
  // *********************************************************************
  typedef enum logic [3:0] {
    NBA_OP_ADD         = 4'h0,
    NBA_OP_SUM_CARRY   = 4'h1,
    NBA_OP_SUB         = 4'h2,
    NBA_OP_DIFF_BORROW = 4'h3,
    NBA_OP_OR          = 4'h4,
    NBA_OP_AND         = 4'h5,
    NBA_OP_XOR         = 4'h6,
    NBA_OP_TEST_ONES   = 4'h7,
    NBA_OP_TEST_ZEROS  = 4'h8,
    NBA_OP_EQ          = 4'h9,
    NBA_OP_NE          = 4'hA,
    NBA_OP_GE          = 4'hB,
    NBA_OP_LT          = 4'hC,
    NBA_OP_ROT_CARRY   = 4'hD
  } nba_op_t;

  // Operand form: register with memory, or memory with immediate
  typedef enum logic {
    NBA_FORM_REG_MEM = 1'b0,
    NBA_FORM_MEM_IMM = 1'b1
  } nba_form_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    NBA_ST_IDLE = 2'b01,
    NBA_ST_EXEC = 2'b10
  } nba_state_t;

  typedef struct packed {
    nba_op_t op;
    nba_form_t form;
    logic [3:0] reg_data;
    logic [3:0] mem_data;
    logic [3:0] imm;
  } nba_req_t;

  typedef struct packed {
    logic to_mem;
    logic [3:0] data;
  } nba_wb_t;

endpackage

// ===== core/nba_bcd_conv.sv
// Decimal conversion stage for the nibble ALU
`timescale 1ns/100ps
`include "nba_regs.svh"
module nba_bcd_conv
  import nba_pkg::*;
(
  input wire logic [4:0] raw_i,
  input wire logic sub_i,
  output logic [3:0] nib_o,
  output logic carry_o
);

  // Out-of-range sums and differences follow a fixed pattern, not a rule
  always_comb begin
    nib_o = raw_i[3:0];
    carry_o = 1'b1;
    if (!sub_i && raw_i < `NBA_BCD_TEN) begin
      carry_o = 1'b0; // RULE5
    end else if (!sub_i && raw_i < `NBA_BCD_TWENTY) begin
      nib_o = 4'(raw_i - `NBA_BCD_TEN); // RULE5
    end else if (sub_i && !raw_i[4] && raw_i < `NBA_BCD_TEN) begin
      carry_o = 1'b0;
    end else if (sub_i && raw_i >= `NBA_BCD_NEG_TEN) begin
      nib_o = 4'(raw_i + `NBA_BCD_TEN); // RULE7
    end else begin
      case ({sub_i, raw_i}) // RULE3 RULE4
        6'h14, 6'h18, 6'h2C, 6'h30, 6'h34: nib_o = 4'hE;
        6'h15, 6'h19, 6'h2D, 6'h31, 6'h35: nib_o = 4'hF;
        6'h16, 6'h1A, 6'h1E, 6'h2A, 6'h2E, 6'h32: nib_o = 4'hC;
        6'h17, 6'h1B, 6'h1F, 6'h2B, 6'h2F, 6'h33: nib_o = 4'hD;
        6'h1C: nib_o = 4'hA;
        6'h1D: nib_o = 4'hB;
        default: nib_o = raw_i[3:0];
      endcase
    end
  end

endmodule

// ===== core/nba_alu.sv
// Nibble ALU datapath with status flags and an AXI4-Lite register port
//
// Overview of operation
// RULE1 - Decimal flag clear: arithmetic is plain 4-bit binary.
// RULE2 - Decimal flag set: binary result passes through decimal conversion.
// RULE3 - Decimal sum of 20 or more gives table nibble 1010B up, carry set.
// RULE4 - Decimal difference outside -10..+9 gives table nibble, carry set.
// RULE5 - Decimal sum 0..9 kept, carry clear; 10..19 minus ten, carry set.
// RULE6 - Binary sum keeps low nibble; carry set when sum reaches 16.
// RULE7 - Negative difference: binary two's complement, decimal plus ten.
// RULE8 - Operands are latched into temporary A and B before operating.
// RULE9 - A from register or memory; B from memory or immediate.
// RULE10 - Rotate uses only a general register; no second operand.
// RULE11 - Arithmetic, logical, rotate results go back to first operand.
// RULE12 - Bit tests and comparisons write nothing; they decide a skip.
// RULE13 - Logical ops ignore mode flags and leave zero and carry alone.
// RULE14 - Any bit test clears the compare-only flag.
// RULE15 - Add, add with carry, subtract, subtract with borrow exist.
// RULE16 - Each arithmetic op has register/memory and memory/immediate forms.
// RULE17 - Compare-only gates write back; decimal flag picks the arithmetic.
// RULE18 - With compare-only set the result is dropped, flags still update.
// RULE19 - Nonzero clears zero; zero result sets it unless compare-only.
// RULE20 - Carry variants inject carry as LSB; carry then shows new value.
// RULE21 - Rotate moves carry into bit 3 and bit 0 into carry.
// RULE22 - Status flags and program status word are one storage.
`timescale 1ns/100ps
`include "nba_regs.svh"
module nba_alu
  import nba_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire nba_req_t req_i,
  output logic req_ready_o,
  output logic wb_valid_o,
  output nba_wb_t wb_o,
  output logic skip_valid_o,
  output logic skip_o,
  output logic [3:0] psw_o,
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [AW-1:0] axi_awaddr_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  output logic [1:0] axi_bresp_o,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  input wire logic [AW-1:0] axi_araddr_i,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o
);

  // *********************************************************************
  // Declarations
  // *********************************************************************
  nba_state_t state_r;
  nba_op_t op_r;
  logic form_mem_r;
  logic [3:0] tmp_a_r;
  logic [3:0] tmp_b_r;
  logic carry_r;
  logic zero_r;
  logic cmp_only_r;
  logic bcd_r;
  logic [3:0] last_res_r;
  logic last_skip_r;
  logic wb_valid_r;
  nba_wb_t wb_r;
  logic skip_valid_r;
  logic skip_r;
  logic aw_hold_r;
  logic [AW-1:0] awaddr_r;
  logic w_hold_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic take;
  logic exec;
  logic is_arith;
  logic is_sub;
  logic is_logic;
  logic is_eval;
  logic is_bit;
  logic cin;
  logic [4:0] raw5;
  logic [3:0] conv_nib;
  logic conv_cy;
  logic [3:0] res_nib;
  logic res_cy;
  logic skip_nxt;
  logic wr_fire;
  logic psw_we;
  localparam logic [3:0] PSW_RST = `NBA_PSW_RST;

  // *********************************************************************
  // Sequencer handshake
  // *********************************************************************
  assign req_ready_o = (state_r == NBA_ST_IDLE);
  assign take = req_valid_i && req_ready_o;
  assign exec = (state_r == NBA_ST_EXEC);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r <= NBA_ST_IDLE;
    end else begin
      case (state_r)
        NBA_ST_IDLE: begin
          if (take) begin
            state_r <= NBA_ST_EXEC;
          end
        end
        NBA_ST_EXEC: state_r <= NBA_ST_IDLE;
        default: state_r <= NBA_ST_IDLE;
      endcase
    end
  end

  // *********************************************************************
  // Operand latch
  // *********************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      op_r <= NBA_OP_ADD;
      form_mem_r <= 1'b0;
      tmp_a_r <= 4'h0;
      tmp_b_r <= 4'h0;
    end else if (take) begin
      op_r <= req_i.op;
      form_mem_r <= (req_i.form == NBA_FORM_MEM_IMM);
      if (req_i.op == NBA_OP_ROT_CARRY) begin
        tmp_a_r <= req_i.reg_data; // RULE10
        tmp_b_r <= 4'h0; // RULE10
      end else if (req_i.op inside {NBA_OP_TEST_ONES, NBA_OP_TEST_ZEROS}) begin
        // Bit tests only exist as memory with an immediate bit mask
        tmp_a_r <= req_i.mem_data; // RULE8
        tmp_b_r <= req_i.imm; // RULE8
      end else if (req_i.form == NBA_FORM_REG_MEM) begin
        tmp_a_r <= req_i.reg_data; // RULE8 RULE9 RULE16
        tmp_b_r <= req_i.mem_data; // RULE9
      end else begin
        tmp_a_r <= req_i.mem_data; // RULE9 RULE16
        tmp_b_r <= req_i.imm; // RULE9
      end
    end
  end

  // *********************************************************************
  // Operation decode and arithmetic
  // *********************************************************************
  assign is_arith = (op_r inside {NBA_OP_ADD, NBA_OP_SUM_CARRY,
                                  NBA_OP_SUB, NBA_OP_DIFF_BORROW}); // RULE15
  assign is_sub = (op_r inside {NBA_OP_SUB, NBA_OP_DIFF_BORROW});
  assign is_logic = (op_r inside {NBA_OP_OR, NBA_OP_AND, NBA_OP_XOR});
  assign is_bit = (op_r inside {NBA_OP_TEST_ONES, NBA_OP_TEST_ZEROS});
  assign is_eval = is_bit ||
                   (op_r inside {NBA_OP_EQ, NBA_OP_NE, NBA_OP_GE, NBA_OP_LT});

  // Only the carry and borrow variants pull in the current carry
  assign cin = (op_r inside {NBA_OP_SUM_CARRY, NBA_OP_DIFF_BORROW}) ?
               carry_r : 1'b0; // RULE15 RULE20

  // Bit 4 of the raw value is the binary carry or borrow
  assign raw5 = is_sub ?
    5'({1'b0, tmp_a_r} - {1'b0, tmp_b_r} - {4'h0, cin}) :
    5'({1'b0, tmp_a_r} + {1'b0, tmp_b_r} + {4'h0, cin}); // RULE20

  nba_bcd_conv u_conv (
    .raw_i(raw5),
    .sub_i(is_sub),
    .nib_o(conv_nib),
    .carry_o(conv_cy)
  );

  always_comb begin
    res_nib = tmp_a_r;
    res_cy = carry_r;
    if (is_arith) begin
      if (bcd_r) begin
        res_nib = conv_nib; // RULE2
        res_cy = conv_cy; // RULE2
      end else begin
        res_nib = raw5[3:0]; // RULE1 RULE6 RULE7
        res_cy = raw5[4]; // RULE6 RULE7
      end
    end else if (op_r == NBA_OP_OR) begin
      res_nib = tmp_a_r | tmp_b_r;
    end else if (op_r == NBA_OP_AND) begin
      res_nib = tmp_a_r & tmp_b_r;
    end else if (op_r == NBA_OP_XOR) begin
      res_nib = tmp_a_r ^ tmp_b_r;
    end else if (op_r == NBA_OP_ROT_CARRY) begin
      res_nib = {carry_r, tmp_a_r[3:1]}; // RULE21
      res_cy = tmp_a_r[0]; // RULE21
    end
  end

  // Comparisons read as unsigned nibbles
  always_comb begin
    case (op_r)
      NBA_OP_TEST_ONES: skip_nxt = ((tmp_a_r & tmp_b_r) == tmp_b_r);
      NBA_OP_TEST_ZEROS: skip_nxt = ((tmp_a_r & tmp_b_r) == 4'h0);
      NBA_OP_EQ: skip_nxt = (tmp_a_r == tmp_b_r);
      NBA_OP_NE: skip_nxt = (tmp_a_r != tmp_b_r);
      NBA_OP_GE: skip_nxt = (tmp_a_r >= tmp_b_r);
      NBA_OP_LT: skip_nxt = (tmp_a_r < tmp_b_r);
      default: skip_nxt = 1'b0;
    endcase
  end

  // *********************************************************************
  // Write back and skip decision
  // *********************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      wb_valid_r <= 1'b0;
      wb_r <= '0;
    end else begin
      // Arithmetic under compare-only leaves both operands untouched
      wb_valid_r <= exec && !is_eval &&
                    !(is_arith && cmp_only_r); // RULE11 RULE17 RULE18
      if (exec) begin
        wb_r.data <= res_nib; // RULE11
        wb_r.to_mem <= form_mem_r &&
                       (op_r != NBA_OP_ROT_CARRY); // RULE11 RULE10
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      skip_valid_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      skip_valid_r <= exec && is_eval; // RULE12
      if (exec && is_eval) begin
        skip_r <= skip_nxt; // RULE12
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      last_res_r <= 4'h0;
      last_skip_r <= 1'b0;
    end else if (exec) begin
      last_res_r <= res_nib;
      last_skip_r <= is_eval && skip_nxt;
    end
  end

  assign wb_valid_o = wb_valid_r;
  assign wb_o = wb_r;
  assign skip_valid_o = skip_valid_r;
  assign skip_o = skip_r;

  // *********************************************************************
  // Status flags, shared with the program status word
  // *********************************************************************
  // An instruction finishing in the cycle of a bus write wins the flag
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      carry_r <= PSW_RST[`NBA_PSW_CARRY];
    end else if (exec && (is_arith || op_r == NBA_OP_ROT_CARRY)) begin
      carry_r <= res_cy; // RULE13 RULE20 RULE21
    end else if (psw_we) begin
      carry_r <= wdata_r[`NBA_PSW_CARRY]; // RULE22
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      zero_r <= 1'b0;
    end else if (exec && is_arith) begin
      if (res_nib != 4'h0) begin
        zero_r <= 1'b0; // RULE19
      end else if (!cmp_only_r) begin
        zero_r <= 1'b1; // RULE19
      end
    end else if (psw_we) begin
      zero_r <= wdata_r[`NBA_PSW_ZERO]; // RULE22
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cmp_only_r <= 1'b0;
    end else if (exec && is_bit) begin
      cmp_only_r <= 1'b0; // RULE14
    end else if (psw_we) begin
      cmp_only_r <= wdata_r[`NBA_PSW_CMPONLY]; // RULE22
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bcd_r <= 1'b0;
    end else if (psw_we) begin
      bcd_r <= wdata_r[`NBA_PSW_BCD]; // RULE22
    end
  end

  always_comb begin
    psw_o = 4'h0;
    psw_o[`NBA_PSW_CARRY] = carry_r;
    psw_o[`NBA_PSW_ZERO] = zero_r;
    psw_o[`NBA_PSW_CMPONLY] = cmp_only_r;
    psw_o[`NBA_PSW_BCD] = bcd_r;
  end

  // *********************************************************************
  // AXI4-Lite write channel
  // *********************************************************************
  // Address and data are held separately so either may arrive first
  assign axi_awready_o = !aw_hold_r && !bvalid_r;
  assign axi_wready_o = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign psw_we = wr_fire && wstrb0_r && (awaddr_r == `NBA_PSW_OFS);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (axi_awvalid_i && axi_awready_o) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= axi_awaddr_i;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end else if (axi_wvalid_i && axi_wready_o) begin
      w_hold_r <= 1'b1;
      wdata_r <= axi_wdata_i;
      wstrb0_r <= axi_wstrb_i[0];
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= `NBA_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      // The status register is read-only; writes to it are refused
      bresp_r <= (awaddr_r == `NBA_PSW_OFS) ? `NBA_RESP_OKAY :
                 `NBA_RESP_SLVERR;
    end else if (axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  assign axi_bvalid_o = bvalid_r;
  assign axi_bresp_o = bresp_r;

  // *********************************************************************
  // AXI4-Lite read channel
  // *********************************************************************
  assign axi_arready_o = !rvalid_r;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `NBA_RESP_OKAY;
    end else if (axi_arvalid_i && axi_arready_o) begin
      rvalid_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `NBA_RESP_OKAY;
      if (axi_araddr_i == `NBA_PSW_OFS) begin
        rdata_r[3:0] <= psw_o; // RULE22
      end else if (axi_araddr_i == `NBA_STAT_OFS) begin
        rdata_r[`NBA_STAT_TMPA_LSB +: 4] <= tmp_a_r;
        rdata_r[`NBA_STAT_TMPB_LSB +: 4] <= tmp_b_r;
        rdata_r[`NBA_STAT_RES_LSB +: 4] <= last_res_r;
        rdata_r[`NBA_STAT_BUSY] <= exec;
        rdata_r[`NBA_STAT_SKIP] <= last_skip_r;
      end else begin
        rresp_r <= `NBA_RESP_SLVERR;
      end
    end else if (axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  assign axi_rvalid_o = rvalid_r;
  assign axi_rdata_o = rdata_r;
  assign axi_rresp_o = rresp_r;

endmodule

// ===== test/nba_alu_chk.sv
// Concurrent checks on the nibble ALU ports
`timescale 1ns/100ps
module nba_alu_chk
  import nba_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire nba_req_t req_i,
  input wire logic req_ready_o,
  input wire logic wb_valid_o,
  input wire nba_wb_t wb_o,
  input wire logic skip_valid_o,
  input wire logic skip_o,
  input wire logic [3:0] psw_o,
  input wire logic axi_awvalid_i,
  input wire logic axi_awready_o,
  input wire logic axi_wvalid_i,
  input wire logic axi_wready_o,
  input wire logic axi_bvalid_o
);
  // ****************************************************
  // Helpers
  // ****************************************************
  logic tk;
  logic [4:0] sum;
  logic [4:0] dsum;
  assign tk = req_valid_i && req_ready_o;
  assign sum = req_i.form ? req_i.mem_data + req_i.imm
                          : req_i.reg_data + req_i.mem_data;
  assign dsum = sum < 5'h0A ? sum : sum - 5'h0A;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // Flags are judged only when no bus write lands beside the result
  sequence settle;
    (!$rose(axi_bvalid_o)) [*2];
  endsequence
  sequence take_op(nba_op_t o, logic [1:0] m);
    tk && req_i.op == o && psw_o[3:2] == m ##1 settle;
  endsequence
  sequence take_in(logic [3:0] lo, logic [3:0] hi);
    tk && req_i.op >= lo && req_i.op <= hi ##1 settle;
  endsequence

  // ****************************************************
  // Assertions
  // ****************************************************
  take_hold_a: assert property (tk |=> !req_ready_o ##1 req_ready_o)
    else $error("request port not busy for one cycle");
  logic_wb_a: assert property (take_in(4'h4, 4'h6) |-> wb_valid_o &&
    wb_o.to_mem == $past(req_i.form, 2) && psw_o[1:0] == $past(psw_o[1:0]))
    else $error("logical op write or flags wrong");
  bin_add_a: assert property (take_op(NBA_OP_ADD, 2'b00) |->
    wb_valid_o && wb_o.to_mem == $past(req_i.form, 2) &&
    wb_o.data == $past(sum[3:0], 2) && psw_o[0] == $past(sum[4], 2))
    else $error("binary sum wrong");
  dec_add_a: assert property (take_op(NBA_OP_ADD, 2'b10) |->
    $past(sum, 2) > 5'h13 || (wb_o.data == $past(dsum[3:0], 2) &&
    psw_o[0] == ($past(sum, 2) > 5'h09)))
    else $error("decimal sum wrong");
  zero_keep_a: assert property (take_op(NBA_OP_ADD, 2'b01) |->
    psw_o[1] == ($past(sum[3:0], 2) == 4'h0 && $past(psw_o[1], 2)))
    else $error("zero flag wrong under compare only");
  cmp_drop_a: assert property (tk && req_i.op <= 4'h3 && psw_o[2]
    ##1 settle |-> !wb_valid_o && !skip_valid_o)
    else $error("compare only result was written");
  eval_skip_a: assert property (take_in(4'h7, 4'hC) |->
    skip_valid_o && !wb_valid_o)
    else $error("evaluation gave no skip or wrote");
  test_clr_a: assert property (take_in(4'h7, 4'h8) |-> !psw_o[2])
    else $error("bit test left compare only set");
  ones_skip_a: assert property (
    take_op(NBA_OP_TEST_ONES, psw_o[3:2]) |->
    skip_o == (($past(req_i.mem_data, 2) & $past(req_i.imm, 2)) ==
    $past(req_i.imm, 2)))
    else $error("ones test skip wrong");
  rot_carry_a: assert property (take_in(4'hD, 4'hD) |->
    wb_o == {1'b0, $past(psw_o[0], 2), $past(req_i.reg_data[3:1], 2)} &&
    psw_o[0] == $past(req_i.reg_data[0], 2))
    else $error("rotate through carry wrong");
  bus_wr_a: assert property (axi_awvalid_i && axi_awready_o &&
    axi_wvalid_i && axi_wready_o |-> ##2 axi_bvalid_o)
    else $error("write answer late");
endmodule

bind nba_alu nba_alu_chk #(.AW(AW)) u_chk (.*);

// ===== test/nba_seq_mdl.sv
// Sequencer model that issues one request at a time
`timescale 1ns/100ps
module nba_seq_mdl
  import nba_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic go_i,
  input wire nba_req_t cmd_i,
  input wire logic req_ready_i,
  output logic req_valid_o = 1'b0,
  output nba_req_t req_o = '0
);
  // Payload is inverted once taken so a stale value never looks valid
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      req_valid_o <= 1'b0;
    end else if (go_i) begin
      req_valid_o <= 1'b1;
      req_o <= cmd_i;
    end else if (req_valid_o && req_ready_i) begin
      req_valid_o <= 1'b0;
      req_o <= ~req_o;
    end
  end
endmodule

// ===== test/test_nba_alu.sv
// Self-checking bench for the nibble ALU
`timescale 1ns/100ps
module test_nba_alu;
  import nba_pkg::*;
  localparam logic [47:0] HI_SUM = 48'hDCBADCFEDCFE;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic go = 1'b0;
  nba_req_t cmd = '0;
  logic req_valid_i, req_ready_o, wb_valid_o, skip_valid_o, skip_o;
  nba_req_t req_i;
  nba_wb_t wb_o;
  logic [3:0] psw_o;
  logic axi_awvalid_i = 1'b0, axi_wvalid_i = 1'b0, axi_bready_i = 1'b0;
  logic axi_arvalid_i = 1'b0, axi_rready_i = 1'b0;
  logic axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o;
  logic axi_rvalid_o;
  logic [7:0] axi_awaddr_i = '0, axi_araddr_i = '0;
  logic [31:0] axi_wdata_i = '0, axi_rdata_o;
  logic [3:0] axi_wstrb_i = '0;
  logic [1:0] axi_bresp_o, axi_rresp_o;
  int n_errors = 0;
  int compares = 0;
  logic [3:0] psw_m = 4'h0, e_dat, e_a, e_b;
  logic e_wb, e_tm, e_sv, e_sk;

  always #4 mclk_i = ~mclk_i;

  nba_alu #(.AW(8)) u_dut (.*);
  nba_seq_mdl u_seq (.mclk_i(mclk_i), .resetn_i(resetn_i), .go_i(go),
    .cmd_i(cmd), .req_ready_i(req_ready_o), .req_valid_o(req_valid_i),
    .req_o(req_i));

  // ****************************************************
  // Checking and closing
  // ****************************************************
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************
  // Reference model of one instruction
  // ****************************************************
  task automatic model(input nba_req_t q);
    int a, b, r;
    logic c;
    a = q.form ? q.mem_data : q.reg_data;
    b = q.form ? q.imm : q.mem_data;
    e_tm = q.form;
    e_dat = 4'h0;
    e_sk = 1'b0;
    if (q.op inside {NBA_OP_TEST_ONES, NBA_OP_TEST_ZEROS}) begin
      a = q.mem_data;
      b = q.imm;
    end
    if (q.op == NBA_OP_ROT_CARRY) begin
      a = q.reg_data;
      b = 0;
      e_tm = 1'b0;
    end
    e_a = a[3:0];
    e_b = b[3:0];
    e_sv = q.op inside {[NBA_OP_TEST_ONES:NBA_OP_LT]};
    e_wb = !e_sv && !(q.op <= NBA_OP_DIFF_BORROW && psw_m[2]);
    case (q.op)
      NBA_OP_OR: e_dat = a | b;
      NBA_OP_AND: e_dat = a & b;
      NBA_OP_XOR: e_dat = a ^ b;
      NBA_OP_TEST_ONES: e_sk = (a & b) == b;
      NBA_OP_TEST_ZEROS: e_sk = (a & b) == 0;
      NBA_OP_EQ: e_sk = a == b;
      NBA_OP_NE: e_sk = a != b;
      NBA_OP_GE: e_sk = a >= b;
      NBA_OP_LT: e_sk = a < b;
      NBA_OP_ROT_CARRY: begin
        e_dat = {psw_m[0], a[3:1]};
        psw_m[0] = a[0];
      end
      default: begin
        c = (q.op inside {NBA_OP_SUM_CARRY, NBA_OP_DIFF_BORROW}) & psw_m[0];
        r = q.op[1] ? a - b - c : a + b + c;
        if (!psw_m[3]) begin
          e_dat = r[3:0];
          c = q.op[1] ? r < 0 : r > 15;
        end else if (!q.op[1]) begin
          e_dat = r < 10 ? r : r < 20 ? r - 10 : HI_SUM[(r - 20) * 4 +: 4];
          c = r > 9;
        end else begin
          e_dat = r >= 0 && r < 10 ? r : r < 0 && r >= -10 ? r + 10
                  : 12 + ((r + 6) & 3);
          c = r < 0 || r > 9;
        end
        psw_m[0] = c;
        if (e_dat != 4'h0) psw_m[1] = 1'b0;
        else if (!psw_m[2]) psw_m[1] = 1'b1;
      end
    endcase
    if (q.op inside {NBA_OP_TEST_ONES, NBA_OP_TEST_ZEROS}) psw_m[2] = 1'b0;
  endtask

  // ****************************************************
  // Drivers
  // ****************************************************
  task automatic run(input nba_req_t q);
    logic [35:0] g, e;
    model(q);
    @(posedge mclk_i);
    go <= 1'b1;
    cmd <= q;
    @(posedge mclk_i);
    go <= 1'b0;
    @(negedge mclk_i);
    while (!req_ready_o) @(negedge mclk_i);
    repeat (2) @(posedge mclk_i);
    #1;
    g = {wb_valid_o, wb_valid_o ? wb_o : 5'h0, skip_valid_o,
         skip_valid_o & skip_o, psw_o};
    e = {e_wb, e_wb ? {e_tm, e_dat} : 5'h0, e_sv, e_sv & e_sk, psw_m};
    chk(g, e);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    @(posedge mclk_i);
    axi_awvalid_i <= 1'b1;
    axi_wvalid_i <= 1'b1;
    axi_awaddr_i <= a;
    axi_wdata_i <= d;
    axi_wstrb_i <= s;
    axi_bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (axi_awready_o) axi_awvalid_i <= 1'b0;
      if (axi_wready_o) axi_wvalid_i <= 1'b0;
    end while (!axi_bvalid_o);
    axi_bready_i <= 1'b0;
    chk(axi_bresp_o, er);
    if (er == 2'h0 && a == 8'h00 && s[0]) psw_m = d[3:0];
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [1:0] er);
    @(posedge mclk_i);
    axi_arvalid_i <= 1'b1;
    axi_araddr_i <= a;
    axi_rready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (axi_arready_o) axi_arvalid_i <= 1'b0;
    end while (!axi_rvalid_o);
    axi_rready_i <= 1'b0;
    chk({axi_rresp_o, axi_rdata_o & m}, {er, d});
  endtask

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    nba_req_t q;
    void'($urandom(32'h7E8566FF));
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    axr(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
    axw(8'h04, 32'h5, 4'hF, 2'h2);
    axw(8'h08, 32'h5, 4'hF, 2'h2);
    axr(8'h08, 32'h0, 32'hFFFFFFFF, 2'h2);
    axw(8'h00, 32'hF, 4'hE, 2'h0);
    for (int m = 0; m < 4; m++) begin
      axw(8'h00, 32'(m << 2), 4'h1, 2'h0);
      chk(psw_o, psw_m);
      for (int i = 0; i < 1024; i++) begin
        q = 17'($urandom);
        q.op = nba_op_t'(i % 4);
        if (q.form) {q.mem_data, q.imm} = i[9:2];
        else {q.reg_data, q.mem_data} = i[9:2];
        run(q);
      end
    end
    for (int i = 0; i < 400; i++) begin
      if (i % 16 == 0) axw(8'h00, $urandom, 4'h1, 2'h0);
      q = 17'($urandom);
      if (q.op > NBA_OP_ROT_CARRY) q.op = NBA_OP_ROT_CARRY;
      run(q);
      // Result nibble is only meaningful for ops that produce one
      axr(8'h04, {e_sv & e_sk, 1'b0, e_dat, e_b, e_a},
          e_sv ? 32'h30FF : 32'h3FFF, 2'h0);
    end
    end_sim;
  end

  initial begin
    repeat (80000) @(posedge mclk_i);
    n_errors++;
    end_sim;
  end
endmodule
